/* File: rtl/mac_stats.sv */
`timescale 1ns/1ns
module mac_stats
    import mac_stats_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    input  wire logic                tx_done_i,
    input  wire logic [mac_stats_pkg::COL_W-1:0] tx_collisions_i,
    input  wire logic                tx_underrun_i,
    input  wire logic                tx_deferred_i,
    input  wire logic                tx_late_col_i,
    input  wire logic                tx_carrier_err_i,
    input  wire logic                rx_done_i,
    input  wire logic                rx_addr_match_i,
    input  wire logic                rx_copied_i,
    input  wire logic                rx_no_buffer_i,
    input  wire logic [mac_stats_pkg::LEN_W-1:0] rx_length_i,
    input  wire logic                rx_fcs_bad_i,
    input  wire logic                rx_odd_bits_i,
    input  wire logic                rx_symbol_err_i,
    output logic                     rx_enable_o,
    output logic                     full_duplex_o
);
    import mac_stats_pkg::*;

    typedef struct packed {
        logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
        logic                          rx_en;
        logic                          wr_en;
        logic                          full_duplex;
        logic                          long_en;
        logic                          jumbo_en;
        logic                          wr_pend;
        logic [7:0]                    wr_addr;
        logic [31:0]                   rdata;
    } state_t;

    state_t             s_q;
    state_t             s_d;
    logic               take;
    logic [7:0]         addr;
    logic [NUM_CNT-1:0] inc;
    logic [NUM_CNT-1:0] rd_clr;
    logic [NUM_CNT-1:0] wr_hit;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt_next;
    logic [LEN_W-1:0]   len_max;
    logic               len_ok;
    logic               rx_bad;
    logic               tx_ok;
    logic               tx_col_free;

    // address phase is taken on a valid transfer while the bus is ready
    assign take = hsel_i && hready_i && htrans_i[1];
    assign addr = haddr_i[7:0];

    // event decode
    assign len_max = s_q.jumbo_en ? LEN_JUMBO : (s_q.long_en ? LEN_LONG : LEN_MAX);
    assign len_ok  = (rx_length_i >= LEN_MIN) && (rx_length_i <= len_max);
    assign rx_bad  = rx_fcs_bad_i || rx_symbol_err_i;
    assign tx_ok   = tx_done_i && !tx_underrun_i && (tx_collisions_i < COL_EXCESS);
    assign tx_col_free = tx_ok && (tx_collisions_i == '0);

    assign inc[IDX_SINGLE_COL] = tx_ok && (tx_collisions_i == COL_ONE);
    assign inc[IDX_MULTI_COL]  = tx_ok && (tx_collisions_i > COL_ONE)
                                 && (tx_collisions_i <= COL_MULTI);
    assign inc[IDX_GOOD_RX]    = s_q.rx_en && rx_done_i && len_ok && !rx_bad && !rx_odd_bits_i
                                 && rx_addr_match_i && rx_copied_i;
    assign inc[IDX_CRC_ERR]    = s_q.rx_en && rx_done_i && len_ok && !rx_odd_bits_i && rx_bad;
    assign inc[IDX_ALIGN_ERR]  = s_q.rx_en && rx_done_i && len_ok && rx_odd_bits_i && rx_bad;
    assign inc[IDX_DEFERRED]   = tx_col_free && tx_deferred_i && !tx_late_col_i;
    assign inc[IDX_LATE_COL]   = tx_done_i && !tx_underrun_i && tx_late_col_i;
    assign inc[IDX_EXCESS_COL] = tx_done_i && !tx_underrun_i && (tx_collisions_i >= COL_EXCESS);
    assign inc[IDX_UNDERRUN]   = tx_done_i && tx_underrun_i;
    assign inc[IDX_CARRIER]    = tx_col_free && tx_carrier_err_i && !s_q.full_duplex;
    assign inc[IDX_NO_BUFFER]  = s_q.rx_en && rx_done_i && rx_addr_match_i && rx_no_buffer_i;

    // per-counter update: write, clear on read, saturating advance
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        localparam logic [7:0] CNT_ADDR = 8'(CNT_BASE + 8'(i * 4));
        logic [CNT_W-1:0] base;

        assign rd_clr[i] = take && !hwrite_i && (addr == CNT_ADDR);
        assign wr_hit[i] = s_q.wr_pend && s_q.wr_en && (s_q.wr_addr == CNT_ADDR);
        assign base      = rd_clr[i] ? '0 : s_q.cnt[i];

        always_comb begin
            if (wr_hit[i]) begin
                cnt_next[i] = hwdata_i[CNT_W-1:0] & CNT_MAX[i];
            end else if (inc[i] && (base != CNT_MAX[i])) begin
                cnt_next[i] = base + CNT_W'(1);
            end else begin
                cnt_next[i] = base;
            end
        end
    end

    always_comb begin
        s_d         = s_q;
        s_d.cnt     = cnt_next;
        s_d.wr_pend = take && hwrite_i;
        s_d.wr_addr = take ? addr : s_q.wr_addr;
        // data phase of a control write
        if (s_q.wr_pend) begin
            case (s_q.wr_addr)
                CTRL_OFS: begin
                    s_d.rx_en = hwdata_i[RX_EN_BIT];
                    s_d.wr_en = hwdata_i[WR_EN_BIT];
                end
                NCFG_OFS: begin
                    s_d.full_duplex = hwdata_i[FULL_DUPLEX_BIT];
                    s_d.jumbo_en    = hwdata_i[JUMBO_BIT];
                    s_d.long_en     = hwdata_i[LONG_BIT];
                end
                default: begin
                end
            endcase
        end
        // read data captured at the address phase edge
        s_d.rdata = '0;
        if (take && !hwrite_i) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (rd_clr[i]) begin
                    s_d.rdata[CNT_W-1:0] = s_q.cnt[i];
                end
            end
            if (addr == CTRL_OFS) begin
                s_d.rdata[RX_EN_BIT] = s_q.rx_en;
                s_d.rdata[WR_EN_BIT] = s_q.wr_en;
            end
            if (addr == NCFG_OFS) begin
                s_d.rdata[FULL_DUPLEX_BIT] = s_q.full_duplex;
                s_d.rdata[JUMBO_BIT]       = s_q.jumbo_en;
                s_d.rdata[LONG_BIT]        = s_q.long_en;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q             <= '0;
            s_q.rx_en       <= CTRL_RST[RX_EN_BIT];
            s_q.wr_en       <= CTRL_RST[WR_EN_BIT];
            s_q.full_duplex <= NCFG_RST[FULL_DUPLEX_BIT];
            s_q.jumbo_en    <= NCFG_RST[JUMBO_BIT];
            s_q.long_en     <= NCFG_RST[LONG_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata_o      = s_q.rdata;
    assign hreadyout_o   = 1'b1;
    assign hresp_o       = HRESP_OKAY;
    assign rx_enable_o   = s_q.rx_en;
    assign full_duplex_o = s_q.full_duplex;

    // checks
    a_single_col_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_collisions_i == 5'h01 && !rd_clr[IDX_SINGLE_COL]
        && !wr_hit[IDX_SINGLE_COL] && s_q.cnt[IDX_SINGLE_COL] != CNT_MAX[IDX_SINGLE_COL]
        |=> s_q.cnt[IDX_SINGLE_COL] == $past(s_q.cnt[IDX_SINGLE_COL]) + 24'h00_0001)
        else $error("single collision count did not advance");

    a_multi_col_range: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_MULTI_COL] |-> tx_collisions_i >= 5'h02 && tx_collisions_i <= 5'h0F && !tx_underrun_i)
        else $error("multiple collision count outside two to fifteen");

    a_good_rx_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_GOOD_RX] && !rd_clr[IDX_GOOD_RX] && !wr_hit[IDX_GOOD_RX]
        && s_q.cnt[IDX_GOOD_RX] != CNT_MAX[IDX_GOOD_RX]
        |=> s_q.cnt[IDX_GOOD_RX] == $past(s_q.cnt[IDX_GOOD_RX]) + 24'h00_0001)
        else $error("good frame count did not advance");

    a_good_rx_clean: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_GOOD_RX] |-> rx_length_i >= 14'h0040 && !rx_fcs_bad_i && !rx_symbol_err_i && !rx_odd_bits_i)
        else $error("good frame counted with an error or short length");

    a_length_limit: assert property (@(posedge clock_i) disable iff (rst_i)
        rx_done_i && ((!s_q.long_en && !s_q.jumbo_en && rx_length_i > 14'h05EE)
        || (!s_q.jumbo_en && rx_length_i > 14'h0600) || rx_length_i > 14'h2800)
        |-> !inc[IDX_GOOD_RX] && !inc[IDX_CRC_ERR] && !inc[IDX_ALIGN_ERR])
        else $error("overlong frame counted as valid length");

    a_crc_error: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && len_ok && !rx_odd_bits_i && (rx_fcs_bad_i || rx_symbol_err_i)
        |-> inc[IDX_CRC_ERR] && !inc[IDX_ALIGN_ERR] && !inc[IDX_GOOD_RX])
        else $error("crc error not counted");

    a_align_error: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && len_ok && rx_odd_bits_i && (rx_fcs_bad_i || rx_symbol_err_i)
        |-> inc[IDX_ALIGN_ERR] && !inc[IDX_CRC_ERR])
        else $error("alignment error not counted");

    a_defer_blocked: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && (tx_collisions_i != 5'h00 || tx_underrun_i) |-> !inc[IDX_DEFERRED])
        else $error("deferral counted with collision or underrun");

    a_late_twice: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_late_col_i && tx_collisions_i == 5'h01
        |-> inc[IDX_LATE_COL] && inc[IDX_SINGLE_COL])
        else $error("late collision not counted twice");

    a_excess_col: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_collisions_i == 5'h10
        |-> inc[IDX_EXCESS_COL] && !inc[IDX_SINGLE_COL] && !inc[IDX_MULTI_COL])
        else $error("excessive collisions not counted");

    a_underrun_alone: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && tx_underrun_i |-> inc[IDX_UNDERRUN] && !inc[IDX_SINGLE_COL] && !inc[IDX_MULTI_COL]
        && !inc[IDX_DEFERRED] && !inc[IDX_LATE_COL] && !inc[IDX_EXCESS_COL] && !inc[IDX_CARRIER])
        else $error("underrun frame advanced another counter");

    a_carrier_half: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_CARRIER] |-> !s_q.full_duplex && tx_collisions_i == 5'h00 && !tx_underrun_i)
        else $error("carrier error counted in full duplex or with collision");

    a_no_buffer: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_NO_BUFFER] |-> rx_addr_match_i && rx_no_buffer_i && s_q.rx_en)
        else $error("no-buffer count without matching frame");

    a_saturate_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.cnt[IDX_LATE_COL] == 24'h00_00FF && !rd_clr[IDX_LATE_COL] && !wr_hit[IDX_LATE_COL]
        ##1 !rd_clr[IDX_LATE_COL] && !wr_hit[IDX_LATE_COL] |-> s_q.cnt[IDX_LATE_COL] == 24'h00_00FF)
        else $error("counter wrapped past all ones");

    a_read_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_clr[IDX_UNDERRUN] && !inc[IDX_UNDERRUN] |=> s_q.cnt[IDX_UNDERRUN] == 24'h00_0000
        && hrdata_o[CNT_W-1:0] == $past(s_q.cnt[IDX_UNDERRUN]))
        else $error("read did not return and clear the count");

    a_rx_gated: assert property (@(posedge clock_i) disable iff (rst_i)
        !s_q.rx_en |-> !inc[IDX_GOOD_RX] && !inc[IDX_CRC_ERR] && !inc[IDX_ALIGN_ERR] && !inc[IDX_NO_BUFFER])
        else $error("receive counter advanced while receive disabled");

    a_write_blocked: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.wr_pend && !s_q.wr_en && s_q.wr_addr == CNT_BASE && !inc[IDX_SINGLE_COL] && !rd_clr[IDX_SINGLE_COL]
        |=> $stable(s_q.cnt[IDX_SINGLE_COL]))
        else $error("counter written while write enable clear");

    a_reset_clear: assert property (@(posedge clock_i)
        rst_i |=> s_q.cnt == '0 && hrdata_o == 32'h0000_0000)
        else $error("reset did not clear counters");

    a_single_only: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_SINGLE_COL]
        |-> tx_collisions_i == 5'h01
        && !tx_underrun_i)
        else $error("single collision count with wrong collisions");

    a_multi_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_MULTI_COL] && !rd_clr[IDX_MULTI_COL] && !wr_hit[IDX_MULTI_COL]
        && s_q.cnt[IDX_MULTI_COL] != 24'h00_FFFF
        |=> s_q.cnt[IDX_MULTI_COL] == $past(s_q.cnt[IDX_MULTI_COL]) + 24'h00_0001)
        else $error("multiple collision count did not advance");

    a_good_copied: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_GOOD_RX]
        |-> rx_addr_match_i && rx_copied_i
        && rx_done_i && s_q.rx_en)
        else $error("good frame counted without match or copy");

    a_short_frame: assert property (@(posedge clock_i) disable iff (rst_i)
        rx_done_i && rx_length_i < 14'h0040
        |-> !inc[IDX_GOOD_RX] && !inc[IDX_CRC_ERR]
        && !inc[IDX_ALIGN_ERR])
        else $error("short frame counted as valid length");

    a_long_limit: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && s_q.long_en && rx_length_i == 14'h0600
        && rx_fcs_bad_i && !rx_odd_bits_i
        |-> inc[IDX_CRC_ERR])
        else $error("long frame limit not applied");

    a_jumbo_limit: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && s_q.jumbo_en && rx_length_i == 14'h2800
        && rx_fcs_bad_i && rx_odd_bits_i
        |-> inc[IDX_ALIGN_ERR])
        else $error("jumbo frame limit not applied");

    a_crc_symbol: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && rx_length_i == 14'h0040
        && rx_symbol_err_i && !rx_odd_bits_i
        |-> inc[IDX_CRC_ERR])
        else $error("symbol error not counted as crc error");

    a_align_symbol: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.rx_en && rx_done_i && rx_length_i == 14'h05EE
        && rx_symbol_err_i && rx_odd_bits_i
        |-> inc[IDX_ALIGN_ERR])
        else $error("symbol error not counted as alignment error");

    a_defer_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_collisions_i == 5'h00
        && tx_deferred_i && !tx_late_col_i
        |-> inc[IDX_DEFERRED])
        else $error("deferred frame not counted");

    a_late_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_LATE_COL] && !rd_clr[IDX_LATE_COL] && !wr_hit[IDX_LATE_COL]
        && s_q.cnt[IDX_LATE_COL] != 24'h00_00FF
        |=> s_q.cnt[IDX_LATE_COL] == $past(s_q.cnt[IDX_LATE_COL]) + 24'h00_0001)
        else $error("late collision count did not advance");

    a_late_multi: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_late_col_i
        && tx_collisions_i >= 5'h02 && tx_collisions_i <= 5'h0F
        |-> inc[IDX_LATE_COL] && inc[IDX_MULTI_COL])
        else $error("late collision missing from collision count");

    a_underrun_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && tx_underrun_i && !rd_clr[IDX_UNDERRUN] && !wr_hit[IDX_UNDERRUN]
        && s_q.cnt[IDX_UNDERRUN] != 24'h00_00FF
        |=> s_q.cnt[IDX_UNDERRUN] == $past(s_q.cnt[IDX_UNDERRUN]) + 24'h00_0001)
        else $error("underrun count did not advance");

    a_carrier_adv: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done_i && !tx_underrun_i && tx_collisions_i == 5'h00
        && tx_carrier_err_i && !s_q.full_duplex
        |-> inc[IDX_CARRIER])
        else $error("carrier sense error not counted");

    a_carrier_only: assert property (@(posedge clock_i) disable iff (rst_i)
        inc[IDX_CARRIER]
        |-> !inc[IDX_SINGLE_COL] && !inc[IDX_MULTI_COL]
        && !inc[IDX_EXCESS_COL] && !inc[IDX_UNDERRUN])
        else $error("carrier sense error advanced another counter");

    a_write_lands: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.wr_pend && s_q.wr_en && s_q.wr_addr == CNT_BASE
        |=> s_q.cnt[IDX_SINGLE_COL]
        == ($past(hwdata_i[CNT_W-1:0]) & 24'h00_FFFF))
        else $error("enabled counter write did not land");

    a_wide_saturate: assert property (@(posedge clock_i) disable iff (rst_i)
        s_q.cnt[IDX_DEFERRED] == 24'h00_FFFF
        && !rd_clr[IDX_DEFERRED] && !wr_hit[IDX_DEFERRED]
        |=> s_q.cnt[IDX_DEFERRED] == 24'h00_FFFF)
        else $error("sixteen-bit counter wrapped past all ones");

endmodule

/* File: rtl/mac_stats_pkg.sv */
package mac_stats_pkg;

    localparam int NUM_CNT = 11;
    localparam int CNT_W   = 24;
    localparam int LEN_W   = 14;
    localparam int COL_W   = 5;

    typedef logic [CNT_W-1:0] cnt_t;

    // counter indices, one word each from CNT_BASE
    localparam int IDX_SINGLE_COL = 0;
    localparam int IDX_MULTI_COL  = 1;
    localparam int IDX_GOOD_RX    = 2;
    localparam int IDX_CRC_ERR    = 3;
    localparam int IDX_ALIGN_ERR  = 4;
    localparam int IDX_DEFERRED   = 5;
    localparam int IDX_LATE_COL   = 6;
    localparam int IDX_EXCESS_COL = 7;
    localparam int IDX_UNDERRUN   = 8;
    localparam int IDX_CARRIER    = 9;
    localparam int IDX_NO_BUFFER  = 10;

    // saturation values per counter
    localparam cnt_t CNT_MAX [NUM_CNT] = '{
        24'h00_FFFF, 24'h00_FFFF, 24'hFF_FFFF, 24'h00_00FF, 24'h00_00FF, 24'h00_FFFF,
        24'h00_00FF, 24'h00_00FF, 24'h00_00FF, 24'h00_00FF, 24'h00_FFFF};

    // byte offsets
    localparam logic [7:0] CNT_BASE = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h40;
    localparam logic [7:0] NCFG_OFS = 8'h44;

    // network_control_reg fields
    localparam int RX_EN_BIT = 2;
    localparam int WR_EN_BIT = 7;
    // network_config_reg fields
    localparam int FULL_DUPLEX_BIT = 1;
    localparam int JUMBO_BIT       = 3;
    localparam int LONG_BIT        = 8;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] NCFG_RST = 32'h0000_0000;

    // frame length limits in bytes
    localparam logic [LEN_W-1:0] LEN_MIN   = 14'h0040;
    localparam logic [LEN_W-1:0] LEN_MAX   = 14'h05EE;
    localparam logic [LEN_W-1:0] LEN_LONG  = 14'h0600;
    localparam logic [LEN_W-1:0] LEN_JUMBO = 14'h2800;

    localparam logic [COL_W-1:0] COL_ONE    = 5'h01;
    localparam logic [COL_W-1:0] COL_MULTI  = 5'h0F;
    localparam logic [COL_W-1:0] COL_EXCESS = 5'h10;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

/* File: tb/frame_engine_model.sv */
`timescale 1ns/1ns
module frame_engine_model
    import mac_stats_pkg::*;
(
    input  wire logic                            clock_i,
    output logic                                 tx_done_o,
    output logic [mac_stats_pkg::COL_W-1:0]      tx_col_o,
    output logic [3:0]                           tx_flags_o,
    output logic                                 rx_done_o,
    output logic [mac_stats_pkg::LEN_W-1:0]      rx_len_o,
    output logic [5:0]                           rx_flags_o
);
    initial begin
        tx_done_o = 1'b0;
        tx_col_o = '0;
        tx_flags_o = '0;
        rx_done_o = 1'b0;
        rx_len_o = '0;
        rx_flags_o = '0;
    end

    // one pulse per frame; qualifiers flip once the pulse is gone
    task automatic tx_frame(input logic [COL_W-1:0] c, input logic [3:0] f);
        @(posedge clock_i);
        tx_done_o <= 1'b1;
        tx_col_o <= c;
        tx_flags_o <= f;
        @(posedge clock_i);
        tx_done_o <= 1'b0;
        tx_col_o <= ~c;
        tx_flags_o <= ~f;
    endtask

    task automatic rx_frame(input logic [LEN_W-1:0] l, input logic [5:0] f);
        @(posedge clock_i);
        rx_done_o <= 1'b1;
        rx_len_o <= l;
        rx_flags_o <= f;
        @(posedge clock_i);
        rx_done_o <= 1'b0;
        rx_len_o <= ~l;
        rx_flags_o <= ~f;
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import mac_stats_pkg::*;
    logic              clock_i, rst_i, hsel, hwrite, hready, hresp, rx_en, fdx, txd, rxd;
    logic [31:0]       haddr, hwdata, hrdata, ctrl, ncfg, rd;
    logic [1:0]        htrans;
    logic [COL_W-1:0]  txc;
    logic [3:0]        txf;
    logic [LEN_W-1:0]  rxl;
    logic [5:0]        rxf;
    cnt_t              exp_cnt [NUM_CNT];
    logic [LEN_W-1:0]  lens [8];
    int                errors, samples_checked;

    mac_stats mac_stats_inst (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .tx_done_i(txd), .tx_collisions_i(txc),
        .tx_underrun_i(txf[3]), .tx_deferred_i(txf[2]), .tx_late_col_i(txf[1]), .tx_carrier_err_i(txf[0]),
        .rx_done_i(rxd), .rx_addr_match_i(rxf[5]), .rx_copied_i(rxf[4]), .rx_no_buffer_i(rxf[3]),
        .rx_length_i(rxl), .rx_fcs_bad_i(rxf[2]), .rx_odd_bits_i(rxf[1]), .rx_symbol_err_i(rxf[0]),
        .rx_enable_o(rx_en), .full_duplex_o(fdx));
    frame_engine_model frame_engine_model_inst (.clock_i(clock_i), .tx_done_o(txd), .tx_col_o(txc),
        .tx_flags_o(txf), .rx_done_o(rxd), .rx_len_o(rxl), .rx_flags_o(rxf));

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, want, seen);
        end
    endtask

    function automatic void bump(int i);
        if (exp_cnt[i] != CNT_MAX[i]) exp_cnt[i] = exp_cnt[i] + 1'b1;
    endfunction

    function automatic void tx_exp(logic [COL_W-1:0] c, logic [3:0] f);
        if (f[3]) bump(IDX_UNDERRUN);
        else begin
            if (c == COL_ONE) bump(IDX_SINGLE_COL);
            if (c > COL_ONE && c <= COL_MULTI) bump(IDX_MULTI_COL);
            if (c >= COL_EXCESS) bump(IDX_EXCESS_COL);
            if (f[1]) bump(IDX_LATE_COL);
            if (f[2] && c == 0 && !f[1]) bump(IDX_DEFERRED);
            if (f[0] && c == 0 && !ncfg[FULL_DUPLEX_BIT]) bump(IDX_CARRIER);
        end
    endfunction

    function automatic void rx_exp(logic [LEN_W-1:0] l, logic [5:0] f);
        logic [LEN_W-1:0] mx;
        logic ok;
        mx = ncfg[JUMBO_BIT] ? LEN_JUMBO : (ncfg[LONG_BIT] ? LEN_LONG : LEN_MAX);
        ok = l >= LEN_MIN && l <= mx;
        if (!ctrl[RX_EN_BIT]) return;
        if (f[5] && f[4] && ok && !f[2] && !f[0]) bump(IDX_GOOD_RX);
        if (ok && (f[2] || f[0]) && !f[1]) bump(IDX_CRC_ERR);
        if (ok && (f[2] || f[0]) && f[1]) bump(IDX_ALIGN_ERR);
        if (f[5] && f[3]) bump(IDX_NO_BUFFER);
    endfunction

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        rd = hrdata;
    endtask

    task automatic setcfg(input logic [31:0] c, input logic [31:0] g);
        ahb(1'b1, CTRL_OFS, c);
        ahb(1'b1, NCFG_OFS, g);
        ctrl = c;
        ncfg = g;
        @(posedge clock_i);
        check("rx_enable", 32'(rx_en), 32'(c[RX_EN_BIT]));
        check("full_duplex", 32'(fdx), 32'(g[FULL_DUPLEX_BIT]));
    endtask

    task automatic chk_all();
        for (int i = 0; i < NUM_CNT; i++) begin
            ahb(1'b0, CNT_BASE + 8'(4 * i), 32'h0000_0000);
            check($sformatf("counter %0d", i), rd, 32'(exp_cnt[i]));
            check("hresp", 32'(hresp), 32'(HRESP_OKAY));
            exp_cnt[i] = '0;
        end
    endtask

    task automatic tx(input logic [COL_W-1:0] c, input logic [3:0] f);
        frame_engine_model_inst.tx_frame(c, f);
        tx_exp(c, f);
    endtask

    task automatic rx(input logic [LEN_W-1:0] l, input logic [5:0] f);
        if (f[1] && !(f[2] || f[0])) f[1] = 1'b0;
        if (f[4] && f[3]) f[3] = 1'b0;
        frame_engine_model_inst.rx_frame(l, f);
        rx_exp(l, f);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        #(40 * 60000);
        errors++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        ctrl = '0;
        ncfg = '0;
        errors = 0;
        samples_checked = 0;
        exp_cnt = '{default: '0};
        lens = '{LEN_MIN - 14'h0001, LEN_MIN, LEN_MAX, LEN_MAX + 14'h0001, LEN_LONG, LEN_LONG + 14'h0001,
                 LEN_JUMBO, LEN_JUMBO + 14'h0001};
        void'($urandom(69682));
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk_all();
        ahb(1'b0, CTRL_OFS, 32'h0000_0000);
        check("network_control_reg", rd, CTRL_RST);
        ahb(1'b0, NCFG_OFS, 32'h0000_0000);
        check("network_config_reg", rd, NCFG_RST);
        ahb(1'b0, 8'h30, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        $display("reset test done");
        for (int d = 0; d < 2; d++) begin
            setcfg(32'h0000_0000, 32'(d) << FULL_DUPLEX_BIT);
            foreach (lens[k])
                for (int f = 0; f < 16; f++) tx(COL_W'(k < 5 ? k : k + 10), 4'(f));
            repeat (100) tx(COL_W'($urandom_range(0, 16)), 4'($urandom));
            chk_all();
        end
        $display("transmit test done");
        for (int m = 0; m < 5; m++) begin
            setcfg(m < 4 ? 32'h0000_0004 : 32'h0000_0000, (32'(m % 2) << LONG_BIT) | (32'(m / 2) << JUMBO_BIT));
            foreach (lens[j])
                for (int f = 0; f < 64; f++) rx(lens[j], 6'(f));
            repeat (100) rx(LEN_W'($urandom_range(40, 10300)), 6'($urandom));
            chk_all();
        end
        $display("receive test done");
        setcfg(32'h0000_0084, 32'h0000_0000);
        for (int i = 0; i < NUM_CNT; i++) begin
            exp_cnt[i] = CNT_MAX[i] - cnt_t'(i % 2);
            ahb(1'b1, CNT_BASE + 8'(4 * i), 32'hFFFF_FFFF - 32'(i % 2));
        end
        tx(COL_ONE, 4'h7);
        tx(5'h00, 4'h5);
        rx(LEN_MIN, 6'h30);
        rx(LEN_MIN, 6'h34);
        rx(LEN_MIN, 6'h23);
        tx(COL_EXCESS, 4'h0);
        chk_all();
        chk_all();
        setcfg(32'h0000_0004, 32'h0000_0000);
        for (int i = 0; i < NUM_CNT; i++) ahb(1'b1, CNT_BASE + 8'(4 * i), 32'h0000_0005);
        chk_all();
        $display("write test done");
        end_of_test();
    end
endmodule
